// ### rtl/u89mp_pkg.sv
package u89mp_pkg;
  // -------------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h98;
  localparam logic [7:0] DATA_ADDR = 8'h99;
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int RX_DONE_BIT = 0;
  localparam int TX_DONE_BIT = 1;
  localparam int NINTH_RX_BIT = 2;
  localparam int NINTH_TX_BIT = 3;
  localparam int RX_EN_BIT = 4;
  localparam int FILTER_BIT = 5;
  localparam int UNUSED_BIT = 6;
  localparam int MODE_BIT = 7;
  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam logic [8:0] TIMER_SPAN = 9'h100;
  localparam logic [3:0] BITS_8BIT = 4'hA;
  localparam logic [3:0] BITS_9BIT = 4'hB;

  // host register access strobe group
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } u89mp_bus_t;
endpackage : u89mp_pkg

// ### rtl/u89mp_bit_timer.sv
`timescale 1ns/1ns
module u89mp_bit_timer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic timerTick,
  input wire logic [7:0] bitTimerReload,
  input wire logic forceLoad,
  output logic overflow,
  output logic bitTick
);
  logic [7:0] bitTimerCount_r;
  logic halfPhase_r;
  wire wrapNow = timerTick && (bitTimerCount_r == 8'hFF);

  // -------------------------------------------------------------------------
  // 8-bit auto-reload counter, overflows halved
  // -------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || forceLoad) begin
      bitTimerCount_r <= sys_rst ? 8'h00 : bitTimerReload;
      halfPhase_r <= 1'b0;
    end else if (timerTick) begin
      bitTimerCount_r <= wrapNow ? bitTimerReload : bitTimerCount_r + 8'h01;
      if (wrapNow) begin
        halfPhase_r <= ~halfPhase_r;
      end
    end
  end

  assign overflow = wrapNow;
  assign bitTick = wrapNow && halfPhase_r;

  timer_reload_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrapNow && !forceLoad |=> bitTimerCount_r == $past(bitTimerReload))
    else $error("bit timer did not reload on overflow");
  tick_halve_a: assert property (@(posedge clk) disable iff (sys_rst)
    bitTick |-> !$past(bitTick))
    else $error("bit tick not halved");
endmodule : u89mp_bit_timer

// ### rtl/u89mp_serial_port.sv
`timescale 1ns/1ns
// Operation
// - bit rate is timer clock over (256 minus reload), then halved
// - control bit 7 selects 8-bit (0) or 9-bit (1) framing
// - 8-bit frame: start, eight data bits LSB first, stop
// - 8-bit mode: received stop level goes into ninth receive bit
// - data buffer write loads shifter and starts transmission
// - transmit done set at start of stop bit
// - receiver starts a character only while receive enable is 1
// - 8-bit load needs receive done clear and, if filtering, stop high
// - on overrun first byte kept, following character discarded
// - failed load leaves buffer, ninth bit and receive done alone
// - 9-bit frame: start, eight data, ninth bit, stop
// - 9-bit mode sends ninth transmit bit as ninth bit
// - 9-bit mode stores ninth bit, ignores stop level
// - 9-bit filtering loads only when ninth bit is 1
// - receive done set at stop bit sampling time
// - interrupt request when either done flag set and enabled
// - control bit 6 reads 1, ignores writes
// - ninth transmit bit unused in 8-bit mode
// - receive timer force-reloaded on detected start
// - bit timer is 8-bit counter reloading on overflow
// - data buffer read returns receive latch only
module u89mp_serial_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire u89mp_pkg::u89mp_bus_t hostBus,
  output logic [7:0] hostRdData,
  input wire logic timerTick,
  input wire logic [7:0] bitTimerReload,
  input wire logic intEnable,
  output logic intReq,
  input wire logic serialRxPin,
  output logic serialTxPin
);
  // -------------------------------------------------------------------------
  // pin synchroniser and control register
  // -------------------------------------------------------------------------
  logic rxMeta_r, rxSync_r, rxPrev_r;
  logic [7:0] ctrl_r;
  logic [7:0] rxLatch_r;
  logic [7:0] rdData_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
      rxPrev_r <= 1'b1;
    end else begin
      rxMeta_r <= serialRxPin;
      rxSync_r <= rxMeta_r;
      rxPrev_r <= rxSync_r;
    end
  end

  wire frameNine = ctrl_r[u89mp_pkg::MODE_BIT];
  wire filterEn = ctrl_r[u89mp_pkg::FILTER_BIT];
  wire rxEnable = ctrl_r[u89mp_pkg::RX_EN_BIT];
  wire ninthTx = ctrl_r[u89mp_pkg::NINTH_TX_BIT];
  wire rxDone = ctrl_r[u89mp_pkg::RX_DONE_BIT];
  wire txDone = ctrl_r[u89mp_pkg::TX_DONE_BIT];
  wire ctrlWr = hostBus.wrEn && (hostBus.addr == u89mp_pkg::CTRL_ADDR);
  wire dataWr = hostBus.wrEn && (hostBus.addr == u89mp_pkg::DATA_ADDR);
  wire [3:0] frameBits = frameNine ? u89mp_pkg::BITS_9BIT : u89mp_pkg::BITS_8BIT;

  // -------------------------------------------------------------------------
  // transmitter
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {U89MP_TX_IDLE, U89MP_TX_SYNC, U89MP_TX_SEND} u89mp_tx_t;
  u89mp_tx_t txState_r;
  logic [9:0] txShift_r;
  logic [3:0] txCount_r;
  logic txOverflow, txTick;

  u89mp_bit_timer txTimer (
    .clk(clk),
    .sys_rst(sys_rst),
    .timerTick(timerTick),
    .bitTimerReload(bitTimerReload),
    .forceLoad(1'b0),
    .overflow(txOverflow),
    .bitTick(txTick)
  );

  wire txLastData = (txState_r == U89MP_TX_SEND) && txTick
    && (txCount_r == frameBits - 4'h2);
  wire txSetDone = txLastData;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txState_r <= U89MP_TX_IDLE;
      txShift_r <= 10'h3FF;
      txCount_r <= 4'h0;
    end else if (dataWr) begin
      // ninth bit only in 9-bit mode; otherwise it is the stop bit
      txShift_r <= {1'b1, frameNine ? ninthTx : 1'b1, hostBus.wrData};
      txState_r <= U89MP_TX_SYNC;
      txCount_r <= 4'h0;
    end else begin
      case (txState_r)
        U89MP_TX_IDLE: begin
          txCount_r <= 4'h0;
        end
        U89MP_TX_SYNC: begin
          if (txTick) begin
            txState_r <= U89MP_TX_SEND; // start bit begins
          end
        end
        U89MP_TX_SEND: begin
          if (txTick) begin
            if (txCount_r == frameBits - 4'h2) begin
              txState_r <= U89MP_TX_IDLE;
            end else begin
              txCount_r <= txCount_r + 4'h1;
              if (txCount_r != 4'h0) begin
                txShift_r <= {1'b1, txShift_r[9:1]};
              end
            end
          end
        end
        default: begin
          txState_r <= U89MP_TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serialTxPin <= 1'b1;
    end else if (txState_r == U89MP_TX_SEND && txCount_r == 4'h0 && !txTick) begin
      serialTxPin <= 1'b0;
    end else if (txState_r == U89MP_TX_SEND) begin
      serialTxPin <= (txCount_r == 4'h0) ? 1'b0 : txShift_r[0];
    end else begin
      serialTxPin <= 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // receiver
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {U89MP_RX_IDLE, U89MP_RX_START, U89MP_RX_DATA} u89mp_rx_t;
  u89mp_rx_t rxState_r;
  logic [8:0] rxShift_r;
  logic [3:0] rxCount_r;
  logic rxOverflow, rxTick;

  wire startSeen = (rxState_r == U89MP_RX_IDLE) && rxEnable && rxPrev_r && !rxSync_r;

  u89mp_bit_timer rxTimer (
    .clk(clk),
    .sys_rst(sys_rst),
    .timerTick(timerTick),
    .bitTimerReload(bitTimerReload),
    .forceLoad(startSeen),
    .overflow(rxOverflow),
    .bitTick()
  );

  // sample at half-bit points: one overflow after start edge, then every two
  logic rxHalf_r;
  wire rxSample = rxOverflow && !rxHalf_r;
  wire rxStopSample = (rxState_r == U89MP_RX_DATA) && rxSample
    && (rxCount_r == frameBits - 4'h2);
  wire stopLevel = rxSync_r;
  wire ninthRx = frameNine ? rxShift_r[8] : stopLevel;
  wire filterPass = !filterEn || ninthRx;
  wire rxLoad = rxStopSample && !rxDone && filterPass;
  wire [8:0] rxShiftIn = frameNine ? {rxSync_r, rxShift_r[8:1]} : {1'b0, rxSync_r, rxShift_r[7:1]};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxState_r <= U89MP_RX_IDLE;
      rxShift_r <= 9'h000;
      rxCount_r <= 4'h0;
      rxHalf_r <= 1'b0;
    end else begin
      if (rxOverflow) begin
        rxHalf_r <= ~rxHalf_r;
      end
      case (rxState_r)
        U89MP_RX_IDLE: begin
          if (startSeen) begin
            rxState_r <= U89MP_RX_START;
            rxHalf_r <= 1'b0;
            rxCount_r <= 4'h0;
          end
        end
        U89MP_RX_START: begin
          if (rxSample) begin
            rxState_r <= rxSync_r ? U89MP_RX_IDLE : U89MP_RX_DATA; // false start
          end
        end
        U89MP_RX_DATA: begin
          if (rxSample) begin
            if (rxStopSample) begin
              rxState_r <= U89MP_RX_IDLE;
            end else begin
              rxShift_r <= rxShiftIn;
              rxCount_r <= rxCount_r + 4'h1;
            end
          end
        end
        default: begin
          rxState_r <= U89MP_RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxLatch_r <= u89mp_pkg::DATA_RESET;
    end else if (rxLoad) begin
      rxLatch_r <= rxShift_r[7:0];
    end
  end

  // -------------------------------------------------------------------------
  // control register, hardware set wins over software clear
  // -------------------------------------------------------------------------
  logic [7:0] ctrl_nxt;
  always_comb begin
    ctrl_nxt = ctrlWr ? hostBus.wrData : ctrl_r;
    ctrl_nxt[u89mp_pkg::UNUSED_BIT] = 1'b1;
    if (rxLoad) begin
      ctrl_nxt[u89mp_pkg::NINTH_RX_BIT] = ninthRx;
      ctrl_nxt[u89mp_pkg::RX_DONE_BIT] = 1'b1;
    end
    if (txSetDone) begin
      ctrl_nxt[u89mp_pkg::TX_DONE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= u89mp_pkg::CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // read port and interrupt
  // -------------------------------------------------------------------------
  wire [7:0] rdSel = (hostBus.addr == u89mp_pkg::CTRL_ADDR) ? ctrl_r
    : (hostBus.addr == u89mp_pkg::DATA_ADDR) ? rxLatch_r : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdData_r <= 8'h00;
    end else if (hostBus.rdEn) begin
      rdData_r <= rdSel;
    end
  end

  assign hostRdData = rdData_r;
  assign intReq = intEnable && (rxDone || txDone);

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  unused_one_a: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_r[u89mp_pkg::UNUSED_BIT])
    else $error("unused control bit not one");
  rx_overrun_a: assert property (@(posedge clk) disable iff (sys_rst)
    rxDone && !ctrlWr |=> $stable(rxLatch_r))
    else $error("receive latch overwritten while full");
  rx_gated_a: assert property (@(posedge clk) disable iff (sys_rst)
    rxStopSample && rxDone && !ctrlWr |=> $stable(ctrl_r[u89mp_pkg::NINTH_RX_BIT]))
    else $error("ninth bit changed on failed load");
  filter_nine_a: assert property (@(posedge clk) disable iff (sys_rst)
    rxLoad && filterEn && frameNine |-> rxShift_r[8])
    else $error("filter passed address bit zero");
  rx_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    rxLoad |=> rxDone && rxLatch_r == $past(rxShift_r[7:0]))
    else $error("receive done or latch missing");
  tx_done_a: assert property (@(posedge clk) disable iff (sys_rst)
    txSetDone && !dataWr |=> txDone)
    else $error("transmit done not set");
  rx_disable_a: assert property (@(posedge clk) disable iff (sys_rst)
    !rxEnable && rxState_r == U89MP_RX_IDLE |=> rxState_r == U89MP_RX_IDLE)
    else $error("receiver started while disabled");
  int_req_a: assert property (@(posedge clk) disable iff (sys_rst)
    intEnable && $rose(rxDone) |-> intReq)
    else $error("interrupt request missing");
  tx_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    dataWr |=> txState_r == U89MP_TX_SYNC)
    else $error("write did not start transmit");

  rx_load_c: cover property (@(posedge clk) rxLoad);
  tx_done_c: cover property (@(posedge clk) txSetDone);
  rx_drop_c: cover property (@(posedge clk) rxStopSample && rxDone);
  nine_load_c: cover property (@(posedge clk) rxLoad && frameNine && filterEn);
endmodule : u89mp_serial_port

// ### verification/u89mp_node_model.sv
`timescale 1ns/1ns
module u89mp_node_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk,
  input wire logic lineIn,
  output logic lineOut
);
  initial lineOut = 1'b1;
  // ----
  // send one character
  // ----
  task automatic sendChar(input logic [7:0] d, input logic nine, input logic b9,
    input logic stp);
    logic [10:0] f;
    int n;
    f = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) lineOut <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
    @(posedge clk) lineOut <= 1'b1;
  endtask : sendChar
  // ----
  // take one character, mid-bit samples
  // ----
  task automatic getChar(output logic [7:0] d, output logic [1:0] tl, output int lowCyc,
    output bit ok);
    logic [10:0] s;
    int w;
    s = '1;
    w = 0;
    lowCyc = 0;
    while (lineIn !== 1'b0 && w < 3000) begin
      @(posedge clk);
      w++;
    end
    ok = (w < 3000);
    for (int c = 0; c < 11 * BIT_CYC; c++) begin
      if (c % BIT_CYC == BIT_CYC / 2) s[c / BIT_CYC] = lineIn;
      if (c <= BIT_CYC + 1 && lineIn === 1'b0) lowCyc++;
      @(posedge clk);
    end
    d = s[8:1];
    tl = s[10:9];
  endtask : getChar
endmodule : u89mp_node_model

// ### verification/test_u89mp_serial_port.sv
`timescale 1ns/1ns
module test_u89mp_serial_port;
  localparam logic [7:0] RELOAD = 8'hFC;
  localparam int BIT_CYC = 16;
  localparam logic [7:0] CA = u89mp_pkg::CTRL_ADDR;
  localparam logic [7:0] DA = u89mp_pkg::DATA_ADDR;
  localparam logic [63:0] RXC = 64'h90B0B030_30001110;
  localparam logic [63:0] RXD = 64'h55447733_6622115A;
  localparam logic [7:0] RX9 = 8'h40;
  localparam logic [7:0] RXS = 8'h77;
  localparam logic [63:0] RXE = 64'hD1F5F075_70405155;
  localparam logic [63:0] RXL = 64'h55443333_5A5A5A5A;
  logic clk, sys_rst, timerTick, intEnable, intReq, rxLine, txLine;
  u89mp_pkg::u89mp_bus_t hostBus;
  logic [7:0] hostRdData, d;
  logic [1:0] tl;
  int errors, compares, lowCyc;
  bit ok;
  u89mp_serial_port i_u89mp_serial_port (.clk(clk), .sys_rst(sys_rst), .hostBus(hostBus),
    .hostRdData(hostRdData), .timerTick(timerTick), .bitTimerReload(RELOAD),
    .intEnable(intEnable), .intReq(intReq), .serialRxPin(rxLine), .serialTxPin(txLine));
  u89mp_node_model #(.BIT_CYC(BIT_CYC)) i_u89mp_node_model (.clk(clk), .lineIn(txLine),
    .lineOut(rxLine));
  // ----
  // clock, tick and watchdog
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) timerTick <= sys_rst ? 1'b0 : ~timerTick;
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    final_report();
  end
  // ----
  // tasks
  // ----
  task automatic final_report;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) hostBus <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: v};
    @(posedge clk) hostBus.wrEn <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) hostBus <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    @(posedge clk) hostBus.rdEn <= 1'b0;
    #1 chk(hostRdData, exp);
  endtask : rdc
  task automatic txc(input logic [7:0] v);
    fork
      i_u89mp_node_model.getChar(d, tl, lowCyc, ok);
      wr(DA, v);
    join
    if (!ok) begin
      errors++;
      final_report();
    end
  endtask : txc
  // ----
  // sequence
  // ----
  initial begin
    sys_rst = 1'b1;
    timerTick = 1'b0;
    intEnable = 1'b0;
    hostBus = '0;
    errors = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(CA, 8'h40);
    rdc(DA, 8'h00);
    wr(CA, 8'h83);
    rdc(CA, 8'hC3);
    chk({7'h00, intReq}, 8'h00);
    @(posedge clk) intEnable <= 1'b1;
    @(posedge clk);
    #1 chk({7'h00, intReq}, 8'h01);
    wr(CA, 8'h00);
    rdc(CA, 8'h40);
    wr(8'h9A, 8'hFF);
    rdc(8'h9A, 8'h00);
    txc(8'hA5);
    chk(d, 8'hA5);
    chk({6'h00, tl}, 8'h03);
    chk(8'(lowCyc), 8'(BIT_CYC));
    rdc(CA, 8'h42);
    chk({7'h00, intReq}, 8'h01);
    for (int b = 0; b < 2; b++) begin
      wr(CA, 8'h80 | 8'(b << 3));
      txc(8'h3C ^ 8'(b));
      chk(d, 8'h3C ^ 8'(b));
      chk({6'h00, tl}, {6'h00, 1'b1, 1'(b)});
    end
    for (int i = 0; i < 8; i++) begin
      wr(CA, RXC[i*8+:8]);
      i_u89mp_node_model.sendChar(RXD[i*8+:8], RXC[i*8+7], RX9[i], RXS[i]);
      repeat (4) @(posedge clk);
      rdc(CA, RXE[i*8+:8]);
      rdc(DA, RXL[i*8+:8]);
      repeat (BIT_CYC) @(posedge clk);
    end
    final_report();
  end
endmodule : test_u89mp_serial_port
